/* File: logic/ms_tick_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module ms_tick_prescaler #(
   parameter int unsigned DIVIDE  = ms_timer_pkg::TICK_CYCLES,
   parameter int unsigned WIDTH   = ms_timer_pkg::PRESCALE_W
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // restart the tick period
   input  wire logic restart,
   // one-cycle millisecond pulse
   output logic      tick
);
   localparam logic [WIDTH-1:0] LAST = WIDTH'(DIVIDE - 1);
   logic [WIDTH-1:0] div_q;

   always_ff @(posedge clk) begin
      if (rst || restart) begin
         div_q <= '0;
      end else if (div_q == LAST) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + WIDTH'(1);
      end
   end

   assign tick = (div_q == LAST) && !restart;

   chk_tick_spacing: assert property (
      @(posedge clk) disable iff (rst)
      tick |=> !tick)
      else $error("tick asserted two cycles running");
endmodule
`default_nettype wire

/* File: logic/ms_timer_pkg.sv */
package ms_timer_pkg;
   // clock and tick timing
   localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
   localparam int unsigned TICK_TIME_US  = 1000;
   localparam int unsigned TICK_CYCLES   =
      (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
   // count span in milliseconds
   localparam int unsigned WRAP_SECONDS  = 500_000;
   localparam int unsigned MS_PER_SECOND = 1000;
   localparam int unsigned COUNT_W       = 29;
   localparam logic [28:0] COUNT_LIMIT   =
      29'(WRAP_SECONDS * MS_PER_SECOND);
   localparam logic [28:0] COUNT_RESET   = 29'h0000_0000;
   localparam int unsigned PRESCALE_W    = 17;
endpackage

/* File: logic/running_millisecond_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module running_millisecond_timer #(
   parameter int unsigned TICK_DIV = ms_timer_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // host load port
   input  wire logic        loadEn,
   input  wire logic [28:0] loadValue,
   // host read port
   output logic [28:0]      countMs,
   output logic             loadRejected
);
   localparam int unsigned PHASE_W = ms_timer_pkg::PRESCALE_W;
   localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(TICK_DIV - 1);

   logic [28:0]        count_q;
   logic               reject_q;
   logic               msTick;
   logic               loadOk;
   logic [PHASE_W-1:0] gap_q;    // spacing of ticks, checks only

   // span check for loads and checks
   function automatic logic withinLimit(input logic [28:0] value);
      return value <= ms_timer_pkg::COUNT_LIMIT;
   endfunction

   assign loadOk = loadEn && withinLimit(loadValue);

   ms_tick_prescaler #(
      .DIVIDE (TICK_DIV),
      .WIDTH  (ms_timer_pkg::PRESCALE_W)
   ) u_prescaler (
      .clk     (clk),
      .rst     (rst),
      .restart (loadOk),
      .tick    (msTick)
   );

   // load timing, one tick every TICK_DIV cycles:
   //   load edge   count takes the value, divider at zero
   //   after that  loaded value stands a full period
   //   TICK_DIV on first step after the load

   always_ff @(posedge clk) begin
      if (rst) begin
         count_q <= ms_timer_pkg::COUNT_RESET;
      end else if (loadOk) begin
         count_q <= loadValue;
      end else if (msTick) begin
         if (count_q >= ms_timer_pkg::COUNT_LIMIT) begin
            count_q <= ms_timer_pkg::COUNT_RESET;
         end else begin
            count_q <= count_q + 29'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reject_q <= 1'h0;
      end else begin
         reject_q <= loadEn && !loadOk;
      end
   end

   // observed tick spacing, feeds the checks only
   always_ff @(posedge clk) begin
      if (rst || loadOk || msTick) begin
         gap_q <= '0;
      end else if (gap_q != '1) begin
         gap_q <= gap_q + PHASE_W'(1);
      end
   end

   assign countMs      = count_q;
   assign loadRejected = reject_q;

   chk_reset_clear: assert property (
      @(posedge clk)
      $fell(rst) |-> count_q == 29'h0000_0000)
      else $error("count not zero after reset");

   // steps only by one on tick
   chk_count_step: assert property (
      @(posedge clk) disable iff (rst)
      (msTick && !loadOk && count_q < ms_timer_pkg::COUNT_LIMIT)
      |=> count_q == $past(count_q) + 29'h0000_0001)
      else $error("count did not step by one");

   chk_count_hold: assert property (
      @(posedge clk) disable iff (rst)
      (!msTick && !loadOk) |=> $stable(count_q))
      else $error("count changed without tick");

   chk_count_wrap: assert property (
      @(posedge clk) disable iff (rst)
      (msTick && !loadOk && count_q == ms_timer_pkg::COUNT_LIMIT)
      |=> count_q == 29'h0000_0000)
      else $error("count did not wrap");

   chk_count_range: assert property (
      @(posedge clk) disable iff (rst)
      withinLimit(count_q))
      else $error("count above limit");

   chk_load_taken: assert property (
      @(posedge clk) disable iff (rst)
      loadOk |=> count_q == $past(loadValue) && !loadRejected)
      else $error("legal load not taken");

   chk_load_refused: assert property (
      @(posedge clk) disable iff (rst)
      (loadEn && !loadOk) |=> loadRejected)
      else $error("illegal load not flagged");

   chk_load_resume: assert property (
      @(posedge clk) disable iff (rst)
      loadOk ##1 !loadEn |-> !msTick)
      else $error("tick too soon after load");

   // tick only at end of period
   chk_tick_early: assert property (
      @(posedge clk) disable iff (rst)
      msTick
      |-> gap_q == PHASE_LAST)
      else $error("tick before its period ended");

   // tick due at end of period
   chk_tick_due: assert property (
      @(posedge clk) disable iff (rst)
      (gap_q == PHASE_LAST && !loadOk)
      |-> msTick)
      else $error("tick missing at end of period");

   chk_gap_bound: assert property (
      @(posedge clk) disable iff (rst)
      gap_q <= PHASE_LAST)
      else $error("tick period overrun");

   chk_tick_gated: assert property (
      @(posedge clk) disable iff (rst)
      loadOk
      |-> !msTick)
      else $error("tick in a load cycle");

   chk_load_restart: assert property (
      @(posedge clk) disable iff (rst)
      loadOk
      |=> !msTick [*2])
      else $error("tick soon after a load");

   chk_upward_only: assert property (
      @(posedge clk) disable iff (rst)
      (!loadOk && !(msTick && count_q == ms_timer_pkg::COUNT_LIMIT))
      |=> count_q >= $past(count_q))
      else $error("count went down");

   chk_no_early_wrap: assert property (
      @(posedge clk) disable iff (rst)
      (msTick && !loadOk && count_q != ms_timer_pkg::COUNT_LIMIT)
      |=> count_q != 29'h0000_0000)
      else $error("count wrapped below limit");

   chk_refused_keeps: assert property (
      @(posedge clk) disable iff (rst)
      (loadEn && !loadOk && !msTick)
      |=> $stable(count_q))
      else $error("refused load changed count");

   chk_reject_pulse: assert property (
      @(posedge clk) disable iff (rst)
      !(loadEn && !loadOk)
      |=> !loadRejected)
      else $error("refusal flag without cause");

   chk_reject_cause: assert property (
      @(posedge clk) disable iff (rst)
      loadRejected
      |-> $past(loadEn) && !withinLimit($past(loadValue)))
      else $error("refusal flag for legal load");

   chk_reset_hold: assert property (
      @(posedge clk)
      rst
      |=> count_q == 29'h0000_0000 && !loadRejected)
      else $error("count or flag not cleared by reset");

   chk_reset_tick: assert property (
      @(posedge clk)
      rst
      |=> !msTick)
      else $error("tick right after reset");
endmodule
`default_nettype wire

/* File: tb/tb_running_millisecond_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin \
   badCount++; $display("wrong value at %0t: %h vs %h", $time, got, exp); \
   end end
module tb_running_millisecond_timer;
   localparam int unsigned DIV = 10;
   logic        clk;
   logic        rst;
   logic        loadEn;
   logic [28:0] loadValue;
   logic [28:0] countMs;
   logic        loadRejected;
   int          badCount = 0;
   int          samplesChecked = 0;
   // timer under test with a short tick period
   running_millisecond_timer #(.TICK_DIV(DIV)) running_millisecond_timer_inst (
      .clk(clk), .rst(rst), .loadEn(loadEn), .loadValue(loadValue),
      .countMs(countMs), .loadRejected(loadRejected));
   // 100 MHz clock
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic testDone();
      $display("checks %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // one-cycle load pulse, returns just after the taking edge
   task automatic loadWord(input logic [28:0] v);
      loadEn = 1;
      loadValue = v;
      @(posedge clk);
      #1 loadEn = 0;
   endtask
   // clear at start, then first ticks from zero
   task automatic runFromReset();
      `CHK(countMs, 29'h0000_0000)
      `CHK(loadRejected, 1'b0)
      repeat (DIV - 1) @(posedge clk);
      #1 `CHK(countMs, 29'h0000_0000)
      @(posedge clk);
      #1 `CHK(countMs, 29'h0000_0001)
   endtask
   // loaded value holds a full period, then steps by one
   task automatic stepAfterLoad(input logic [28:0] v);
      loadWord(v);
      `CHK(countMs, v)
      repeat (DIV - 1) @(posedge clk);
      #1 `CHK(countMs, v)
      @(posedge clk);
      #1 `CHK(countMs, v + 29'h0000_0001)
   endtask
   // limit is legal and wraps on the next tick
   task automatic wrapAtLimit();
      loadWord(ms_timer_pkg::COUNT_LIMIT);
      `CHK(countMs, ms_timer_pkg::COUNT_LIMIT)
      repeat (DIV - 1) @(posedge clk);
      #1 `CHK(countMs, ms_timer_pkg::COUNT_LIMIT)
      @(posedge clk);
      #1 `CHK(countMs, 29'h0000_0000)
      repeat (DIV) @(posedge clk);
      #1 `CHK(countMs, 29'h0000_0001)
   endtask
   // back-to-back legal then illegal load
   task automatic refuseOverLimit();
      loadEn = 1;
      loadValue = 29'h0000_0064;
      @(posedge clk);
      #1 loadValue = ms_timer_pkg::COUNT_LIMIT + 29'h0000_0001;
      @(posedge clk);
      #1 loadEn = 0;
      `CHK(loadRejected, 1'b1)
      `CHK(countMs, 29'h0000_0064)
      @(posedge clk);
      #1 `CHK(loadRejected, 1'b0)
   endtask
   // mid-run reset clears the count
   task automatic resetMidRun();
      loadWord(29'h0000_0032);
      rst = 1;
      @(posedge clk);
      #1 rst = 0;
      `CHK(countMs, 29'h0000_0000)
      runFromReset();
   endtask
   // main sequence
   initial begin
      rst = 1;
      loadEn = 0;
      loadValue = 29'h0000_0000;
      repeat (6) @(posedge clk);
      #1 rst = 0;
      runFromReset();
      stepAfterLoad(29'h0000_0019);
      stepAfterLoad(ms_timer_pkg::COUNT_LIMIT - 29'h0000_0001);
      wrapAtLimit();
      refuseOverLimit();
      resetMidRun();
      testDone();
   end
   // watchdog against a hang
   initial begin
      #100000;
      badCount++;
      testDone();
   end
endmodule
`default_nettype wire
